// *** design/scid_defines.svh ***
// Constants for the servo control input decoder: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SCID_DEFINES_SVH
`define SCID_DEFINES_SVH
`define SCID_AW 8
`define SCID_NPARAM 8
`define SCID_IDX_SETUP 3'h0
`define SCID_IDX_FUNC 3'h1
`define SCID_IDX_LOCK 3'h2
`define SCID_IDX_FLIM 3'h3
`define SCID_IDX_RLIM 3'h4
`define SCID_IDX_ISP1 3'h5
`define SCID_IDX_ISP2 3'h6
`define SCID_IDX_ISP3 3'h7
`define SCID_IDX_STATUS 6'h08
`define SCID_PARAM_RST 16'h0000
`define SCID_SU_BYPASS 0
`define SCID_SU_FWD_OFF 2
`define SCID_SU_REV_OFF 3
`define SCID_SU_STOP_A 6
`define SCID_SU_STOP_B 8
`define SCID_SU_STOP_C 9
`define SCID_FN_SPEED 4'h0
`define SCID_FN_POS 4'h1
`define SCID_FN_TORQUE 4'h2
`define SCID_FN_IS_LO 4'h3
`define SCID_FN_IS_GAIN 4'h5
`define SCID_FN_IS_HI 4'h6
`define SCID_FN_PS 4'h7
`define SCID_FN_PT 4'h8
`define SCID_FN_ST 4'h9
`define SCID_FN_LOCK 4'ha
`define SCID_FN_INHIB 4'hb
`define SCID_IN_W 8
`define SCID_IN_RUN 0
`define SCID_IN_MFI 1
`define SCID_IN_FWD 2
`define SCID_IN_REV 3
`define SCID_IN_SPA 4
`define SCID_IN_SPB 5
`define SCID_IN_EREQ 6
`define SCID_IN_ARST 7
`define SCID_RESP_OK 2'h0
`define SCID_RESP_ERR 2'h2
`endif

// *** design/scid_pkg.sv ***
// Types shared by the servo control input decoder.
// Assumes nothing of its surroundings.
package scid_pkg;
  typedef enum logic [1:0] {
    SCID_MODE_SPEED = 2'h0,
    SCID_MODE_POS = 2'h1,
    SCID_MODE_TORQUE = 2'h2
  } scid_mode_t;
endpackage : scid_pkg

// *** design/scid_sync.sv ***
// Two-stage synchroniser for the control input pins.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "scid_defines.svh"
module scid_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`SCID_IN_W-1:0] pin_raw,
  output logic [`SCID_IN_W-1:0] pin_sync
);
  genvar i;
  for (i = 0; i < `SCID_IN_W; i = i + 1) begin : g_bit
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    always_comb begin
      meta_d = pin_raw[i];
      sync_d = meta_q;
    end
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end
    assign pin_sync[i] = sync_q;
  end
endmodule : scid_sync
`default_nettype wire

// *** design/scid_top.sv ***
// Servo control input decoder: pin decode, encoder supply, AXI4-Lite regs.
// Assumes motor_speed and encoder_ready come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "scid_defines.svh"
module scid_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`SCID_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SCID_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_in,
  input wire logic multi_function_in,
  input wire logic forward_drive_prohibit,
  input wire logic reverse_drive_prohibit,
  input wire logic forward_current_limit_in,
  input wire logic reverse_current_limit_in,
  input wire logic encoder_power_request,
  input wire logic alarm_reset_in,
  input wire logic [15:0] motor_speed,
  input wire logic encoder_ready,
  output logic servo_power_en,
  output logic encoder_supply_en,
  output logic gain_reduce,
  output logic hold_position,
  output logic pulse_inhibit,
  output logic [1:0] control_mode,
  output logic internal_speed_en,
  output logic internal_speed_reverse,
  output logic [15:0] internal_speed,
  output logic fwd_current_limit_en,
  output logic rev_current_limit_en,
  output logic [15:0] fwd_current_limit,
  output logic [15:0] rev_current_limit,
  output logic fwd_drive_permit,
  output logic rev_drive_permit,
  output logic [2:0] overtravel_stop_cfg,
  output logic alarm_clear
);
  logic [`SCID_IN_W-1:0] sy;
  scid_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin_raw({alarm_reset_in, encoder_power_request, reverse_current_limit_in,
              forward_current_limit_in, reverse_drive_prohibit,
              forward_drive_prohibit, multi_function_in, run_in}),
    .pin_sync(sy)
  );

  // Parameter store
  logic [15:0] param_q [`SCID_NPARAM];
  logic [15:0] param_d [`SCID_NPARAM];
  logic [15:0] setup_q;
  logic [3:0] fn;
  assign setup_q = param_q[`SCID_IDX_SETUP];
  assign fn = param_q[`SCID_IDX_FUNC][3:0];

  // Decode state
  logic servo_q, servo_d, enc_q, enc_d, gain_q, gain_d, hold_q, hold_d;
  logic inhib_q, inhib_d, isen_q, isen_d, dir_q, dir_d;
  logic fcl_q, fcl_d, rcl_q, rcl_d, fperm_q, fperm_d, rperm_q, rperm_d;
  logic aclr_q, aclr_d, ereq_prev_q, arst_prev_q;
  logic [1:0] mode_q, mode_d;
  logic [15:0] ispd_q, ispd_d;
  logic [2:0] stop_q, stop_d;
  logic run_eff, mfi, spa, spb, any_sel, is_rng, ereq_rise, ereq_fall, lock_c;
  scid_pkg::scid_mode_t mode_c;

  always_comb begin
    mfi = sy[`SCID_IN_MFI];
    spa = sy[`SCID_IN_SPA];
    spb = sy[`SCID_IN_SPB];
    any_sel = spa | spb;
    is_rng = (fn >= `SCID_FN_IS_LO) && (fn <= `SCID_FN_IS_HI);
    run_eff = setup_q[`SCID_SU_BYPASS] | sy[`SCID_IN_RUN];
    lock_c = (fn == `SCID_FN_LOCK) && mfi
             && (motor_speed < param_q[`SCID_IDX_LOCK]);
    gain_d = mfi && ((fn == `SCID_FN_SPEED) || (fn == `SCID_FN_POS)
             || ((fn >= `SCID_FN_IS_LO) && (fn <= `SCID_FN_IS_GAIN) && !any_sel));
    unique case (fn)
      `SCID_FN_POS: mode_c = scid_pkg::SCID_MODE_POS;
      `SCID_FN_TORQUE: mode_c = scid_pkg::SCID_MODE_TORQUE;
      `SCID_FN_PS: mode_c = mfi ? scid_pkg::SCID_MODE_SPEED
                                : scid_pkg::SCID_MODE_POS;
      `SCID_FN_PT: mode_c = mfi ? scid_pkg::SCID_MODE_TORQUE
                                : scid_pkg::SCID_MODE_POS;
      `SCID_FN_ST: mode_c = mfi ? scid_pkg::SCID_MODE_SPEED
                                : scid_pkg::SCID_MODE_TORQUE;
      `SCID_FN_LOCK: mode_c = lock_c ? scid_pkg::SCID_MODE_POS
                                     : scid_pkg::SCID_MODE_SPEED;
      `SCID_FN_INHIB: mode_c = scid_pkg::SCID_MODE_POS;
      default: mode_c = scid_pkg::SCID_MODE_SPEED;
    endcase
    mode_d = mode_c;
    inhib_d = (fn == `SCID_FN_INHIB) && mfi;
    hold_d = lock_c || inhib_d;
    isen_d = is_rng && any_sel;
    dir_d = is_rng && any_sel && mfi;
    unique case ({spb, spa})
      2'b01: ispd_d = param_q[`SCID_IDX_ISP1];
      2'b10: ispd_d = param_q[`SCID_IDX_ISP2];
      2'b11: ispd_d = param_q[`SCID_IDX_ISP3];
      default: ispd_d = 16'h0000;
    endcase
    if (!is_rng) begin
      ispd_d = 16'h0000;
    end
    fcl_d = !is_rng && spa;
    rcl_d = !is_rng && spb;
    fperm_d = setup_q[`SCID_SU_FWD_OFF] | sy[`SCID_IN_FWD];
    rperm_d = setup_q[`SCID_SU_REV_OFF] | sy[`SCID_IN_REV];
    stop_d = {setup_q[`SCID_SU_STOP_C],
              (mode_c == scid_pkg::SCID_MODE_TORQUE) ? 1'b0
                                                     : setup_q[`SCID_SU_STOP_B],
              setup_q[`SCID_SU_STOP_A]};
    ereq_rise = sy[`SCID_IN_EREQ] && !ereq_prev_q;
    ereq_fall = !sy[`SCID_IN_EREQ] && ereq_prev_q;
    // Rising request wins over any simultaneous cut
    enc_d = ereq_rise || (enc_q && !(ereq_fall && !servo_q && !run_eff));
    servo_d = run_eff && sy[`SCID_IN_EREQ] && enc_q && encoder_ready;
    aclr_d = sy[`SCID_IN_ARST] && !arst_prev_q;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      servo_q <= 1'b0;
      enc_q <= 1'b0;
      gain_q <= 1'b0;
      hold_q <= 1'b0;
      inhib_q <= 1'b0;
      isen_q <= 1'b0;
      dir_q <= 1'b0;
      fcl_q <= 1'b0;
      rcl_q <= 1'b0;
      fperm_q <= 1'b0;
      rperm_q <= 1'b0;
      aclr_q <= 1'b0;
      ereq_prev_q <= 1'b0;
      arst_prev_q <= 1'b0;
      mode_q <= scid_pkg::SCID_MODE_SPEED;
      ispd_q <= 16'h0000;
      stop_q <= 3'h0;
    end else begin
      servo_q <= servo_d;
      enc_q <= enc_d;
      gain_q <= gain_d;
      hold_q <= hold_d;
      inhib_q <= inhib_d;
      isen_q <= isen_d;
      dir_q <= dir_d;
      fcl_q <= fcl_d;
      rcl_q <= rcl_d;
      fperm_q <= fperm_d;
      rperm_q <= rperm_d;
      aclr_q <= aclr_d;
      ereq_prev_q <= sy[`SCID_IN_EREQ];
      arst_prev_q <= sy[`SCID_IN_ARST];
      mode_q <= mode_d;
      ispd_q <= ispd_d;
      stop_q <= stop_d;
    end
  end

  assign servo_power_en = servo_q;
  assign encoder_supply_en = enc_q;
  assign gain_reduce = gain_q;
  assign hold_position = hold_q;
  assign pulse_inhibit = inhib_q;
  assign control_mode = mode_q;
  assign internal_speed_en = isen_q;
  assign internal_speed_reverse = dir_q;
  assign internal_speed = ispd_q;
  assign fwd_current_limit_en = fcl_q;
  assign rev_current_limit_en = rcl_q;
  assign fwd_current_limit = param_q[`SCID_IDX_FLIM];
  assign rev_current_limit = param_q[`SCID_IDX_RLIM];
  assign fwd_drive_permit = fperm_q;
  assign rev_drive_permit = rperm_q;
  assign overtravel_stop_cfg = stop_q;
  assign alarm_clear = aclr_q;

  // AXI4-Lite slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
  logic [5:0] aw_idx_q, aw_idx_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [5:0] ar_idx;
  logic [31:0] status_w;

  always_comb begin
    status_w = {21'h00_0000, dir_q, isen_q, rperm_q, fperm_q, inhib_q,
                hold_q, gain_q, mode_q, enc_q, servo_q};
    ar_idx = s_axi_araddr[`SCID_AW-1:2];
    for (int k = 0; k < `SCID_NPARAM; k++) begin
      param_d[k] = param_q[k];
    end
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_idx_d = aw_idx_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && awrdy_q) begin
      aw_have_d = 1'b1;
      aw_idx_d = s_axi_awaddr[`SCID_AW-1:2];
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `SCID_RESP_OK;
      if (aw_idx_q < `SCID_NPARAM) begin
        for (int b = 0; b < 2; b++) begin
          if (wstrb_q[b]) begin
            param_d[aw_idx_q[2:0]][8*b +: 8] = wdata_q[8*b +: 8];
          end
        end
      end else if (aw_idx_q != `SCID_IDX_STATUS) begin
        bresp_d = `SCID_RESP_ERR;
      end
    end
    awrdy_d = !aw_have_d && !bvalid_d;
    wrdy_d = !w_have_d && !bvalid_d;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arrdy_q) begin
      rvalid_d = 1'b1;
      rresp_d = `SCID_RESP_OK;
      if (ar_idx < `SCID_NPARAM) begin
        rdata_d = {16'h0000, param_q[ar_idx[2:0]]};
      end else if (ar_idx == `SCID_IDX_STATUS) begin
        rdata_d = status_w;
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = `SCID_RESP_ERR;
      end
    end
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int k = 0; k < `SCID_NPARAM; k++) begin
        param_q[k] <= `SCID_PARAM_RST;
      end
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SCID_RESP_OK;
      awrdy_q <= 1'b0;
      wrdy_q <= 1'b0;
      arrdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SCID_RESP_OK;
    end else begin
      param_q <= param_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_idx_q <= aw_idx_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready = wrdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence ereq_rise_s;
    !ereq_prev_q ##0 sy[`SCID_IN_EREQ];
  endsequence
  sequence ereq_cut_s;
    ereq_prev_q && !sy[`SCID_IN_EREQ] && !servo_q && !run_eff;
  endsequence

  run_gate_a: assert property (!run_eff |=> !servo_power_en)
    else $error("servo power without run");
  bypass_on_a: assert property (setup_q[`SCID_SU_BYPASS] && sy[`SCID_IN_EREQ]
    && enc_q && encoder_ready |=> servo_power_en)
    else $error("bypass did not turn servo on");
  gain_role_a: assert property (gain_reduce |-> $past(mfi)
    && ($past(fn) <= `SCID_FN_IS_GAIN) && ($past(fn) != `SCID_FN_TORQUE))
    else $error("gain reduce in wrong role");
  lock_hold_a: assert property (lock_c |=> hold_position
    && control_mode == scid_pkg::SCID_MODE_POS)
    else $error("position lock not applied");
  mode_ps_a: assert property (fn == `SCID_FN_PS |=> control_mode ==
    ($past(mfi) ? scid_pkg::SCID_MODE_SPEED : scid_pkg::SCID_MODE_POS))
    else $error("pos/speed switch wrong");
  mode_pt_a: assert property (fn == `SCID_FN_PT |=> control_mode ==
    ($past(mfi) ? scid_pkg::SCID_MODE_TORQUE : scid_pkg::SCID_MODE_POS))
    else $error("pos/torque switch wrong");
  mode_st_a: assert property (fn == `SCID_FN_ST |=> control_mode ==
    ($past(mfi) ? scid_pkg::SCID_MODE_SPEED : scid_pkg::SCID_MODE_TORQUE))
    else $error("speed/torque switch wrong");
  dir_sel_a: assert property (is_rng && any_sel |=>
    internal_speed_en && internal_speed_reverse == $past(mfi))
    else $error("internal speed direction wrong");
  pulse_off_a: assert property (fn == `SCID_FN_INHIB && mfi |=>
    pulse_inhibit && hold_position)
    else $error("pulse disable not applied");
  permit_a: assert property (##1 fwd_drive_permit == $past(setup_q[`SCID_SU_FWD_OFF]
    | sy[`SCID_IN_FWD]))
    else $error("forward permit wrong");
  torque_stop_a: assert property (control_mode == scid_pkg::SCID_MODE_TORQUE
    |-> !overtravel_stop_cfg[1])
    else $error("torque stop uses bit 8");
  climit_a: assert property (!is_rng |=> fwd_current_limit_en == $past(spa)
    && rev_current_limit_en == $past(spb))
    else $error("current limit select wrong");
  speed_sel_a: assert property (is_rng && spa && spb |=>
    internal_speed == $past(param_q[`SCID_IDX_ISP3]))
    else $error("internal speed select wrong");
  enc_on_a: assert property (ereq_rise_s ##1 sy[`SCID_IN_EREQ]
    |-> encoder_supply_en [*2])
    else $error("encoder supply not switched on");
  enc_cut_a: assert property ((ereq_cut_s and !ereq_rise) |=> !encoder_supply_en)
    else $error("encoder supply not cut");
  enc_keep_a: assert property (servo_q && enc_q |=> encoder_supply_en)
    else $error("encoder supply dropped while powered");
  enc_gate_a: assert property ($rose(servo_power_en) |-> $past(encoder_ready)
    && $past(sy[`SCID_IN_EREQ]) && encoder_supply_en)
    else $error("motor powered before encoder ready");
  sync_a: assert property (##2 sy[`SCID_IN_RUN] == $past(run_in, 2))
    else $error("run synchroniser depth wrong");
endmodule : scid_top
`default_nettype wire

// *** verification/scid_host_model.sv ***
// Host controller model driving the control input pins of the decoder.
// Assumes the bench gives the wanted pin levels; srst marks power-up.
`timescale 1ns/1ps
`default_nettype none
`include "scid_defines.svh"
module scid_host_model #(
  parameter int EREQ_HOLD = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`SCID_IN_W-1:0] want,
  output logic [`SCID_IN_W-1:0] pins
);
  int up_cnt_q;
  logic [`SCID_IN_W-1:0] pins_d;
  always_comb begin
    pins_d = want;
    // Encoder request held off for a scaled wait after power-up
    pins_d[`SCID_IN_EREQ] = want[`SCID_IN_EREQ] && (up_cnt_q >= EREQ_HOLD);
    // Alarm reset only offered with run dropped
    pins_d[`SCID_IN_ARST] = want[`SCID_IN_ARST] && !want[`SCID_IN_RUN];
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      up_cnt_q <= 0;
      pins <= '0;
    end else begin
      up_cnt_q <= (up_cnt_q < EREQ_HOLD) ? up_cnt_q + 1 : up_cnt_q;
      pins <= pins_d;
    end
  end
endmodule : scid_host_model
`default_nettype wire

// *** verification/scid_top_tb.sv ***
// Self-checking bench for scid_top: reset and register tests, table of decode cases, then hand tests.
// Assumes scid_host_model drives the pins and AXI4-Lite reaches the params.
`timescale 1ns/1ps
`default_nettype none
`include "scid_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module scid_top_tb;
  typedef struct packed {
    logic [3:0] fn;
    logic [2:0] pin;
    logic [15:0] spd;
    logic [8:0] exp;
  } scid_row_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic w_run = 1'b0, w_mfi = 1'b0, w_fwd = 1'b1, w_rev = 1'b1;
  logic w_spa = 1'b0, w_spb = 1'b0, w_ereq = 1'b0, w_arst = 1'b0;
  logic encoder_ready = 1'b0;
  logic [15:0] motor_speed = 16'h0000;
  logic [7:0] pins;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, control_mode;
  logic [31:0] s_axi_rdata;
  logic servo_power_en, encoder_supply_en, gain_reduce, hold_position, pulse_inhibit;
  logic internal_speed_en, internal_speed_reverse, fwd_current_limit_en, rev_current_limit_en;
  logic fwd_drive_permit, rev_drive_permit, alarm_clear;
  logic [15:0] internal_speed, fwd_current_limit, rev_current_limit;
  logic [2:0] overtravel_stop_cfg;
  int error_cnt = 0;
  int compares = 0;
  int n;
  scid_row_t rows [19];

  scid_host_model #(.EREQ_HOLD(16)) u_host (.sys_clk, .srst,
    .want({w_arst, w_ereq, w_spb, w_spa, w_rev, w_fwd, w_mfi, w_run}), .pins);
  scid_top u_dut (
    .sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .run_in(pins[`SCID_IN_RUN]), .multi_function_in(pins[`SCID_IN_MFI]),
    .forward_drive_prohibit(pins[`SCID_IN_FWD]), .reverse_drive_prohibit(pins[`SCID_IN_REV]),
    .forward_current_limit_in(pins[`SCID_IN_SPA]),
    .reverse_current_limit_in(pins[`SCID_IN_SPB]),
    .encoder_power_request(pins[`SCID_IN_EREQ]), .alarm_reset_in(pins[`SCID_IN_ARST]),
    .motor_speed, .encoder_ready, .servo_power_en, .encoder_supply_en, .gain_reduce,
    .hold_position, .pulse_inhibit, .control_mode, .internal_speed_en,
    .internal_speed_reverse, .internal_speed, .fwd_current_limit_en, .rev_current_limit_en,
    .fwd_current_limit, .rev_current_limit, .fwd_drive_permit, .rev_drive_permit,
    .overtravel_stop_cfg, .alarm_clear);

  always #2 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask : axi_rd

  // Pin path is host register, two sync stages, decode, supply, then servo
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask : settle

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rows = '{'{4'h0, 3'h6, 16'h0000, 9'h102}, '{4'h1, 3'h5, 16'h0000, 9'h111},
      '{4'h2, 3'h4, 16'h0000, 9'h020}, '{4'h3, 3'h4, 16'h0000, 9'h100},
      '{4'h5, 3'h4, 16'h0000, 9'h100}, '{4'h5, 3'h2, 16'h0000, 9'h008},
      '{4'h6, 3'h5, 16'h0000, 9'h00c}, '{4'h4, 3'h7, 16'h0000, 9'h00c},
      '{4'h6, 3'h4, 16'h0000, 9'h000}, '{4'h7, 3'h7, 16'h0000, 9'h003},
      '{4'h7, 3'h0, 16'h0000, 9'h010}, '{4'h8, 3'h4, 16'h0000, 9'h020},
      '{4'h8, 3'h0, 16'h0000, 9'h010}, '{4'h9, 3'h4, 16'h0000, 9'h000},
      '{4'h9, 3'h0, 16'h0000, 9'h020}, '{4'ha, 3'h4, 16'h00ff, 9'h090},
      '{4'ha, 3'h4, 16'h0100, 9'h000}, '{4'hb, 3'h4, 16'h0000, 9'h0d0},
      '{4'hb, 3'h0, 16'h0000, 9'h010}};
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    `CHK({servo_power_en, encoder_supply_en, gain_reduce, hold_position, pulse_inhibit,
      control_mode, internal_speed_en, internal_speed_reverse, internal_speed,
      fwd_current_limit_en, rev_current_limit_en, fwd_current_limit, rev_current_limit,
      fwd_drive_permit, rev_drive_permit, overtravel_stop_cfg, alarm_clear}, '0)
    axi_rd(8'h04, 32'h0000_0000, 2'h0);
    axi_rd(8'h24, 32'h0000_0000, 2'h2);
    axi_wr(8'h24, 32'h0000_1111, 2'h2);
    axi_wr(8'h20, 32'hffff_ffff, 2'h0);
    axi_wr(8'h08, 32'h0000_0100, 2'h0);
    axi_wr(8'h14, 32'h0000_0011, 2'h0);
    axi_wr(8'h18, 32'h0000_0022, 2'h0);
    axi_wr(8'h1c, 32'h0000_0033, 2'h0);
    axi_wr(8'h0c, 32'h1234_5a5a, 2'h0);
    axi_wr(8'h10, 32'h0000_0777, 2'h0);
    axi_rd(8'h0c, 32'h0000_5a5a, 2'h0);
    `CHK({fwd_current_limit, rev_current_limit}, 32'h5a5a_0777)
    for (int i = 0; i < 19; i++) begin
      axi_wr(8'h04, {28'h000_0000, rows[i].fn}, 2'h0);
      {w_mfi, w_spa, w_spb} <= rows[i].pin;
      motor_speed <= rows[i].spd;
      settle();
      `CHK({gain_reduce, hold_position, pulse_inhibit, control_mode, internal_speed_en,
        internal_speed_reverse, fwd_current_limit_en, rev_current_limit_en},
        rows[i].exp)
      if (rows[i].exp[3]) begin
        `CHK(internal_speed, (rows[i].pin[1:0] == 2'b11) ? 16'h0033 :
          (rows[i].pin[1] ? 16'h0011 : 16'h0022))
      end else begin
        `CHK(internal_speed, 16'h0000)
      end
    end
    {w_mfi, w_spa, w_spb} <= 3'h0;
    axi_wr(8'h04, 32'h0000_0000, 2'h0);
    w_run <= 1'b1;
    w_ereq <= 1'b1;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h1)
    encoder_ready <= 1'b1;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h3)
    w_ereq <= 1'b0;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h1)
    w_ereq <= 1'b1;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h3)
    w_run <= 1'b0;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h1)
    w_ereq <= 1'b0;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h0)
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    w_ereq <= 1'b1;
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h3)
    axi_rd(8'h20, 32'h0000_0183, 2'h0);
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
    settle();
    `CHK({servo_power_en, encoder_supply_en}, 2'h1)
    w_fwd <= 1'b0;
    settle();
    `CHK({fwd_drive_permit, rev_drive_permit}, 2'h1)
    axi_wr(8'h00, 32'h0000_0004, 2'h0);
    settle();
    `CHK({fwd_drive_permit, rev_drive_permit}, 2'h3)
    w_rev <= 1'b0;
    axi_wr(8'h00, 32'h0000_0348, 2'h0);
    settle();
    `CHK({fwd_drive_permit, rev_drive_permit, overtravel_stop_cfg}, 5'h0f)
    axi_wr(8'h04, 32'h0000_0002, 2'h0);
    settle();
    `CHK(overtravel_stop_cfg, 3'h5)
    w_arst <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge sys_clk);
      if (alarm_clear === 1'b1) n++;
    end
    `CHK(n, 1)
    w_arst <= 1'b0;
    settle();
    // Reset in mid-run: outputs and parameters must return to their reset values
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    `CHK({servo_power_en, encoder_supply_en, control_mode, fwd_drive_permit,
      rev_drive_permit, overtravel_stop_cfg, fwd_current_limit}, '0)
    axi_rd(8'h00, 32'h0000_0000, 2'h0);
    settle();
    print_verdict();
  end
endmodule : scid_top_tb
`default_nettype wire
